// File: hdl/crc_acc_pkg.sv
// Constants for the byte CRC accumulator: opcodes, polynomials, offsets.
// Assumes the host pipeline presents whole instruction words with operands.
package crc_acc_pkg;
    // Generator polynomials, MSB-first, implicit top bit
    localparam logic [15:0] POLY_CRC16_P1 = 16'h8005;
    localparam logic [15:0] POLY_CRC16_P2 = 16'h1021;
    localparam logic [23:0] POLY_CRC24    = 24'h5D6DCB;
    localparam logic [31:0] POLY_CRC32_P1 = 32'h04C11DB7;
    localparam logic [31:0] POLY_CRC32_P2 = 32'h1EDC6F41;

    // First instruction words
    localparam logic [15:0] LSW_CRC32_P1_LO = 16'hE2C1;
    localparam logic [15:0] LSW_CRC32_P1_HI = 16'hE2C2;
    localparam logic [15:0] LSW_SHARED      = 16'hE2CB;
    localparam logic [15:0] LSW_CRC16_LO    = 16'hE2CE;
    localparam logic [15:0] LSW_CRC16_HI    = 16'hE2CF;
    localparam logic [15:0] LSW_CLEAR       = 16'hE524;
    localparam logic [15:0] LSW_SET_FLIP    = 16'hE52C;
    localparam logic [15:0] LSW_CLR_FLIP    = 16'hE52D;
    localparam logic [15:0] LSW_POLY_LO_IMM = 16'hE754;
    localparam logic [15:0] LSW_POLY_HI_IMM = 16'hE755;
    localparam logic [7:0]  LSW_MOVE_OUT    = 8'hBF;
    localparam logic [7:0]  LSW_MOVE_IN     = 8'hBD;

    // Upper byte of the second word
    localparam logic [7:0] SUB_P1       = 8'h00;
    localparam logic [7:0] SUB_P2       = 8'h01;
    localparam logic [7:0] SUB_CRC24_LO = 8'h01;
    localparam logic [7:0] SUB_CRC24_HI = 8'h02;
    localparam logic [7:0] SUB_PLEN     = 8'h04;
    localparam logic [7:0] SUB_DLEN     = 8'h05;
    localparam logic [7:0] SUB_C32P2_LO = 8'h08;
    localparam logic [7:0] SUB_C32P2_HI = 8'h09;

    // Absolute address at which moves reach the result register
    localparam logic [15:0] RESULT_ABS_ADDR = 16'h0000;

    // Register port offsets
    localparam logic [3:0] OFS_RESULT = 4'h0;
    localparam logic [3:0] OFS_POLY   = 4'h4;
    localparam logic [3:0] OFS_SIZE   = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;

    // Field positions
    localparam int STATUS_FLIP_BIT = 0;
    localparam int SIZE_DLEN_LSB   = 0;
    localparam int SIZE_PLEN_LSB   = 16;

    // Reset values
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
    localparam logic [31:0] POLY_RESET   = 32'h0000_0000;
    localparam logic [31:0] SIZE_RESET   = 32'h0000_0000;
    localparam logic        FLIP_RESET   = 1'b0;

    typedef enum {
        OP_NONE, OP_C16P1, OP_C16P2, OP_C24, OP_C32P1, OP_C32P2,
        OP_CLEAR, OP_SET_FLIP, OP_CLR_FLIP, OP_POLY_LO, OP_POLY_HI,
        OP_DLEN, OP_PLEN, OP_MOVE_OUT, OP_MOVE_IN
    } op_t;
endpackage

// File: hdl/crc_byte_accumulator.sv
// Byte CRC accumulator: decodes result, polynomial and size instructions.
// Assumes the host pipeline holds operands valid with I_OP_VALID and
// waits while O_BUSY is high; register port reads answer one cycle later.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

// Functional notes
// - CRC16 first polynomial 0x8005 byte update
// - CRC16 second polynomial 0x1021 byte update
// - CRC32 first polynomial 0x04c11db7 byte update
// - CRC32 second polynomial 0x1edc6f41 byte update
// - CRC24 polynomial 0x5D6DCB on low 24 bits
// - Low variants use operand bits 7:0
// - High variants use operand bits 15:8
// - Reverse flag set feeds byte bit-reversed
// - Result register accumulates and stores outcome
// - Only set/clear-flip instructions touch the status flag
// - Clear instruction zeroes whole result register
// - Result-to-CPU move, absolute address, two cycles
// - CPU-to-result move, absolute address, two cycles
// - Lower immediate load zeroes polynomial top half
// - Upper immediate load keeps polynomial low half
// - Data-length write loads its half only
// - Polynomial-length write loads its half only
// - Decode CRC32 low byte, zero sub-byte
// - Decode CRC24 low byte by sub-byte one
// - Decode clear as single opcode word
// - Only set/clear-flip change reverse flag
module crc_byte_accumulator (
    input  wire logic        I_CLOCK,
    input  wire logic        I_RST_N,
    input  wire logic        I_OP_VALID,
    input  wire logic [15:0] I_OPCODE_LSW,
    input  wire logic [15:0] I_OPCODE_MSW,
    input  wire logic [15:0] I_WORD_OPERAND,
    input  wire logic [31:0] I_CPU_DATA,
    input  wire logic [3:0]  I_ADDR,
    input  wire logic [31:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [31:0] O_RDATA,
    output logic      [31:0] O_CRC_RESULT,
    output logic             O_MSG_FLIP,
    output logic             O_BUSY,
    output logic      [31:0] O_CPU_DATA,
    output logic             O_CPU_VALID
);
    logic [31:0]         crc_result_reg;
    logic [31:0]         poly_value_reg;
    logic [31:0]         crc_size_reg;
    logic                msg_bit_reverse_flag;
    logic                busy_reg;
    crc_acc_pkg::op_t    move_op_reg;
    logic                move_hit_reg;
    logic [31:0]         move_data_reg;
    logic [31:0]         cpu_data_reg;
    logic                cpu_valid_reg;
    logic [31:0]         rdata_reg;

    crc_acc_pkg::op_t    op;
    logic                accept;
    logic                byte_hi;
    logic [7:0]          sel_byte;
    logic [7:0]          msg_byte;
    logic [15:0]         c16p1_out;
    logic [15:0]         c16p2_out;
    logic [23:0]         c24_out;
    logic [31:0]         c32p1_out;
    logic [31:0]         c32p2_out;
    logic [31:0]         crc_next;
    logic [7:0]          sub;

    assign sub    = I_OPCODE_MSW[15:8];
    assign accept = I_OP_VALID && !busy_reg;

    // Decoder; the high-byte flag rides in the first word or sub-byte
    always_comb begin
        op      = crc_acc_pkg::OP_NONE;
        byte_hi = 1'b0;
        case (I_OPCODE_LSW)
            crc_acc_pkg::LSW_CRC32_P1_LO: begin
                if (sub == crc_acc_pkg::SUB_P1) op = crc_acc_pkg::OP_C32P1;
            end
            crc_acc_pkg::LSW_CRC32_P1_HI: begin
                if (sub == crc_acc_pkg::SUB_P1) op = crc_acc_pkg::OP_C32P1;
                byte_hi = 1'b1;
            end
            crc_acc_pkg::LSW_CRC16_LO, crc_acc_pkg::LSW_CRC16_HI: begin
                byte_hi = (I_OPCODE_LSW == crc_acc_pkg::LSW_CRC16_HI);
                if (sub == crc_acc_pkg::SUB_P1) op = crc_acc_pkg::OP_C16P1;
                else if (sub == crc_acc_pkg::SUB_P2) op = crc_acc_pkg::OP_C16P2;
            end
            crc_acc_pkg::LSW_SHARED: begin
                case (sub)
                    crc_acc_pkg::SUB_CRC24_LO: op = crc_acc_pkg::OP_C24;
                    crc_acc_pkg::SUB_CRC24_HI: begin
                        op      = crc_acc_pkg::OP_C24;
                        byte_hi = 1'b1;
                    end
                    crc_acc_pkg::SUB_C32P2_LO: op = crc_acc_pkg::OP_C32P2;
                    crc_acc_pkg::SUB_C32P2_HI: begin
                        op      = crc_acc_pkg::OP_C32P2;
                        byte_hi = 1'b1;
                    end
                    crc_acc_pkg::SUB_DLEN: op = crc_acc_pkg::OP_DLEN;
                    crc_acc_pkg::SUB_PLEN: op = crc_acc_pkg::OP_PLEN;
                    default:               op = crc_acc_pkg::OP_NONE;
                endcase
            end
            crc_acc_pkg::LSW_CLEAR:       op = crc_acc_pkg::OP_CLEAR;
            crc_acc_pkg::LSW_SET_FLIP:    op = crc_acc_pkg::OP_SET_FLIP;
            crc_acc_pkg::LSW_CLR_FLIP:    op = crc_acc_pkg::OP_CLR_FLIP;
            crc_acc_pkg::LSW_POLY_LO_IMM: op = crc_acc_pkg::OP_POLY_LO;
            crc_acc_pkg::LSW_POLY_HI_IMM: op = crc_acc_pkg::OP_POLY_HI;
            default: begin
                if (I_OPCODE_LSW[15:8] == crc_acc_pkg::LSW_MOVE_OUT)
                    op = crc_acc_pkg::OP_MOVE_OUT;
                else if (I_OPCODE_LSW[15:8] == crc_acc_pkg::LSW_MOVE_IN)
                    op = crc_acc_pkg::OP_MOVE_IN;
            end
        endcase
    end

    // Message byte selection and optional bit reversal
    always_comb begin
        sel_byte = byte_hi ? I_WORD_OPERAND[15:8] : I_WORD_OPERAND[7:0];
        for (int i = 0; i < 8; i++) begin
            msg_byte[i] = msg_bit_reverse_flag ? sel_byte[7-i] : sel_byte[i];
        end
    end

    crc_byte_step #(.WIDTH(16), .POLY(crc_acc_pkg::POLY_CRC16_P1)) u_c16p1 (
        .i_crc  (crc_result_reg[15:0]),
        .i_byte (msg_byte),
        .o_crc  (c16p1_out)
    );
    crc_byte_step #(.WIDTH(16), .POLY(crc_acc_pkg::POLY_CRC16_P2)) u_c16p2 (
        .i_crc  (crc_result_reg[15:0]),
        .i_byte (msg_byte),
        .o_crc  (c16p2_out)
    );
    crc_byte_step #(.WIDTH(24), .POLY(crc_acc_pkg::POLY_CRC24)) u_c24 (
        .i_crc  (crc_result_reg[23:0]),
        .i_byte (msg_byte),
        .o_crc  (c24_out)
    );
    crc_byte_step #(.WIDTH(32), .POLY(crc_acc_pkg::POLY_CRC32_P1)) u_c32p1 (
        .i_crc  (crc_result_reg),
        .i_byte (msg_byte),
        .o_crc  (c32p1_out)
    );
    crc_byte_step #(.WIDTH(32), .POLY(crc_acc_pkg::POLY_CRC32_P2)) u_c32p2 (
        .i_crc  (crc_result_reg),
        .i_byte (msg_byte),
        .o_crc  (c32p2_out)
    );

    // Narrow CRCs leave the bits above their width untouched
    always_comb begin
        crc_next = crc_result_reg;
        case (op)
            crc_acc_pkg::OP_C16P1: crc_next = {crc_result_reg[31:16], c16p1_out};
            crc_acc_pkg::OP_C16P2: crc_next = {crc_result_reg[31:16], c16p2_out};
            crc_acc_pkg::OP_C24:   crc_next = {crc_result_reg[31:24], c24_out};
            crc_acc_pkg::OP_C32P1: crc_next = c32p1_out;
            crc_acc_pkg::OP_C32P2: crc_next = c32p2_out;
            crc_acc_pkg::OP_CLEAR: crc_next = '0;
            default:               crc_next = crc_result_reg;
        endcase
    end

    // Result register; instructions outrank a same-cycle port write
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            crc_result_reg <= crc_acc_pkg::RESULT_RESET;
        end else if (busy_reg) begin
            if (move_op_reg == crc_acc_pkg::OP_MOVE_IN && move_hit_reg)
                crc_result_reg <= move_data_reg;
        end else if (accept && op != crc_acc_pkg::OP_NONE) begin
            crc_result_reg <= crc_next;
        end else if (I_WR && I_ADDR == crc_acc_pkg::OFS_RESULT) begin
            crc_result_reg <= I_WDATA;
        end
    end

    // Polynomial register
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            poly_value_reg <= crc_acc_pkg::POLY_RESET;
        end else if (accept && op == crc_acc_pkg::OP_POLY_LO) begin
            poly_value_reg <= {16'h0000, I_OPCODE_MSW};
        end else if (accept && op == crc_acc_pkg::OP_POLY_HI) begin
            poly_value_reg <= {I_OPCODE_MSW, poly_value_reg[15:0]};
        end else if (I_WR && I_ADDR == crc_acc_pkg::OFS_POLY
                     && !(accept && op != crc_acc_pkg::OP_NONE)) begin
            poly_value_reg <= I_WDATA;
        end
    end

    // Size register halves
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            crc_size_reg <= crc_acc_pkg::SIZE_RESET;
        end else if (accept && op == crc_acc_pkg::OP_DLEN) begin
            crc_size_reg[crc_acc_pkg::SIZE_DLEN_LSB +: 16] <= I_WORD_OPERAND;
        end else if (accept && op == crc_acc_pkg::OP_PLEN) begin
            crc_size_reg[crc_acc_pkg::SIZE_PLEN_LSB +: 16] <= I_WORD_OPERAND;
        end else if (I_WR && I_ADDR == crc_acc_pkg::OFS_SIZE
                     && !(accept && op != crc_acc_pkg::OP_NONE)) begin
            crc_size_reg <= I_WDATA;
        end
    end

    // Reverse flag; port writes cannot reach it
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            msg_bit_reverse_flag <= crc_acc_pkg::FLIP_RESET;
        end else if (accept && op == crc_acc_pkg::OP_SET_FLIP) begin
            msg_bit_reverse_flag <= 1'b1;
        end else if (accept && op == crc_acc_pkg::OP_CLR_FLIP) begin
            msg_bit_reverse_flag <= 1'b0;
        end
    end

    // Two-cycle mover: capture on accept, complete one cycle later
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            busy_reg      <= 1'b0;
            move_op_reg   <= crc_acc_pkg::OP_NONE;
            move_hit_reg  <= 1'b0;
            move_data_reg <= '0;
        end else if (accept && (op == crc_acc_pkg::OP_MOVE_OUT
                                || op == crc_acc_pkg::OP_MOVE_IN)) begin
            busy_reg      <= 1'b1;
            move_op_reg   <= op;
            move_hit_reg  <= (I_OPCODE_MSW == crc_acc_pkg::RESULT_ABS_ADDR);
            move_data_reg <= I_CPU_DATA;
        end else begin
            busy_reg      <= 1'b0;
            move_op_reg   <= crc_acc_pkg::OP_NONE;
        end
    end

    // Unmatched addresses return zero to the CPU
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cpu_data_reg  <= '0;
            cpu_valid_reg <= 1'b0;
        end else if (busy_reg && move_op_reg == crc_acc_pkg::OP_MOVE_OUT) begin
            cpu_data_reg  <= move_hit_reg ? crc_result_reg : 32'h0000_0000;
            cpu_valid_reg <= 1'b1;
        end else begin
            cpu_valid_reg <= 1'b0;
        end
    end

    // Register port read; unmapped offsets read zero
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rdata_reg <= '0;
        end else if (I_RD) begin
            case (I_ADDR)
                crc_acc_pkg::OFS_RESULT: rdata_reg <= crc_result_reg;
                crc_acc_pkg::OFS_POLY:   rdata_reg <= poly_value_reg;
                crc_acc_pkg::OFS_SIZE:   rdata_reg <= crc_size_reg;
                crc_acc_pkg::OFS_STATUS: begin
                    rdata_reg <= '0;
                    rdata_reg[crc_acc_pkg::STATUS_FLIP_BIT] <= msg_bit_reverse_flag;
                end
                default:                 rdata_reg <= '0;
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    assign O_RDATA      = rdata_reg;
    assign O_CRC_RESULT = crc_result_reg;
    assign O_MSG_FLIP   = msg_bit_reverse_flag;
    assign O_BUSY       = busy_reg;
    assign O_CPU_DATA   = cpu_data_reg;
    assign O_CPU_VALID  = cpu_valid_reg;

    // Checks
    sequence s_move_out_req;
        accept && op == crc_acc_pkg::OP_MOVE_OUT
            && I_OPCODE_MSW == crc_acc_pkg::RESULT_ABS_ADDR;
    endsequence
    sequence s_move_in_req;
        accept && op == crc_acc_pkg::OP_MOVE_IN
            && I_OPCODE_MSW == crc_acc_pkg::RESULT_ABS_ADDR;
    endsequence

    AST_CLEAR_ZERO: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        accept && I_OPCODE_LSW == crc_acc_pkg::LSW_CLEAR |=> crc_result_reg == 32'h0000_0000)
        else $error("clear did not zero result");

    AST_FLAG_ONLY_BY_FLIP_OPS: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        !(accept && (op == crc_acc_pkg::OP_SET_FLIP || op == crc_acc_pkg::OP_CLR_FLIP))
            |=> $stable(msg_bit_reverse_flag))
        else $error("reverse flag changed without flip op");

    AST_FLAG_SET: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        accept && I_OPCODE_LSW == crc_acc_pkg::LSW_SET_FLIP |=> msg_bit_reverse_flag ##1
            (msg_bit_reverse_flag || $past(accept && op == crc_acc_pkg::OP_CLR_FLIP)))
        else $error("set flip not held");

    AST_POLY_LO: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        accept && op == crc_acc_pkg::OP_POLY_LO
            |=> poly_value_reg == {16'h0000, $past(I_OPCODE_MSW)})
        else $error("lower immediate load wrong");

    AST_POLY_HI: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        accept && op == crc_acc_pkg::OP_POLY_HI
            |=> poly_value_reg == {$past(I_OPCODE_MSW), $past(poly_value_reg[15:0])})
        else $error("upper immediate load wrong");

    AST_MOVE_OUT_TWO_CYCLES: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        s_move_out_req |=> O_BUSY && !O_CPU_VALID ##1
            O_CPU_VALID && !O_BUSY && O_CPU_DATA == $past(crc_result_reg))
        else $error("result move out not in two cycles");

    AST_MOVE_IN_TWO_CYCLES: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        s_move_in_req |=> O_BUSY ##1 !O_BUSY && crc_result_reg == $past(I_CPU_DATA, 2))
        else $error("result move in not in two cycles");

    AST_DLEN_HALF: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        accept && op == crc_acc_pkg::OP_DLEN |=> crc_size_reg[15:0] == $past(I_WORD_OPERAND)
            && crc_size_reg[31:16] == $past(crc_size_reg[31:16]))
        else $error("data-length write wrong");

    AST_PLEN_HALF: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        accept && op == crc_acc_pkg::OP_PLEN |=> crc_size_reg[31:16] == $past(I_WORD_OPERAND)
            && crc_size_reg[15:0] == $past(crc_size_reg[15:0]))
        else $error("poly-length write wrong");

    AST_CRC24_TOP_KEPT: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        accept && op == crc_acc_pkg::OP_C24
            |=> crc_result_reg[31:24] == $past(crc_result_reg[31:24]))
        else $error("crc24 touched upper byte");

    AST_CRC32_LO_DECODE: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        I_OPCODE_LSW == crc_acc_pkg::LSW_CRC32_P1_LO && sub == crc_acc_pkg::SUB_P1
            |-> op == crc_acc_pkg::OP_C32P1 && !byte_hi)
        else $error("crc32 low byte not decoded");
endmodule // crc_byte_accumulator

// File: hdl/crc_byte_step.sv
// One MSB-first, non-reflected CRC update over one message byte.
// Pure combinational; caller selects width and polynomial.
`timescale 1ns/1ps
module crc_byte_step #(
    parameter int                WIDTH = 16,
    parameter logic [WIDTH-1:0]  POLY  = '0
) (
    input  wire logic [WIDTH-1:0] i_crc,
    input  wire logic [7:0]       i_byte,
    output logic      [WIDTH-1:0] o_crc
);
    always_comb begin
        logic [WIDTH-1:0] c;
        logic             fb;
        c  = i_crc;
        fb = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            fb = c[WIDTH-1] ^ i_byte[i];
            c  = {c[WIDTH-2:0], 1'b0} ^ (fb ? POLY : '0);
        end
        o_crc = c;
    end
endmodule // crc_byte_step

// File: verification/host_pipe_model.sv
// Host pipeline model: presents whole instructions to the accumulator.
// Assumes callers enter its tasks just after a rising edge of i_clock.
`timescale 1ns/1ps
module host_pipe_model (
    input  wire logic        i_clock,
    input  wire logic        i_busy,
    output logic             o_op_valid,
    output logic      [15:0] o_lsw,
    output logic      [15:0] o_msw,
    output logic      [15:0] o_operand,
    output logic      [31:0] o_cpu_data
);
    initial begin
        o_op_valid = 1'b0;
        o_lsw      = 16'h0000;
        o_msw      = 16'h0000;
        o_operand  = 16'h0000;
        o_cpu_data = 32'h0000_0000;
    end

    // Valid stays up on return so consecutive calls run back to back
    task automatic issue(input logic [15:0] lsw, input logic [15:0] msw,
                         input logic [15:0] opnd, input logic [31:0] cpu);
        o_op_valid <= 1'b1;
        o_lsw      <= lsw;
        o_msw      <= msw;
        o_operand  <= opnd;
        o_cpu_data <= cpu;
        // Refused while busy, so the request is held until it is taken
        @(negedge i_clock);
        while (i_busy) @(negedge i_clock);
        @(posedge i_clock);
        #1;
    endtask

    // Released operand and CPU data lines show no stale value
    task automatic idle();
        o_op_valid <= 1'b0;
        o_operand  <= ~o_operand;
        o_cpu_data <= ~o_cpu_data;
    endtask
endmodule // host_pipe_model

// File: verification/tb_crc_byte_accumulator.sv
// Self-checking bench for the byte CRC accumulator.
// Assumes the host model and the register port share the 250 MHz clock.
`timescale 1ns/1ps
module tb_crc_byte_accumulator;
    logic        clock;
    logic        rst_n;
    logic        op_valid;
    logic [15:0] lsw;
    logic [15:0] msw;
    logic [15:0] operand;
    logic [31:0] cpu_in;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [31:0] crc_res;
    logic        msg_flip;
    logic        busy;
    logic [31:0] cpu_out;
    logic        cpu_valid;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cycles    = 0;
    logic [15:0] tab_lsw [10] = '{16'hE2CE, 16'hE2CF, 16'hE2CE, 16'hE2CF, 16'hE2C1,
                                  16'hE2C2, 16'hE2CB, 16'hE2CB, 16'hE2CB, 16'hE2CB};
    logic [7:0]  tab_sub [10] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00,
                                  8'h00, 8'h08, 8'h09, 8'h01, 8'h02};
    int          tab_w   [10] = '{16, 16, 16, 16, 32, 32, 32, 32, 24, 24};
    logic [31:0] tab_poly[10] = '{32'h8005, 32'h8005, 32'h1021, 32'h1021, 32'h04C11DB7,
                                  32'h04C11DB7, 32'h1EDC6F41, 32'h1EDC6F41,
                                  32'h5D6DCB, 32'h5D6DCB};

    crc_byte_accumulator i_crc_byte_accumulator (
        .I_CLOCK(clock), .I_RST_N(rst_n), .I_OP_VALID(op_valid), .I_OPCODE_LSW(lsw),
        .I_OPCODE_MSW(msw), .I_WORD_OPERAND(operand), .I_CPU_DATA(cpu_in),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .O_CRC_RESULT(crc_res), .O_MSG_FLIP(msg_flip), .O_BUSY(busy),
        .O_CPU_DATA(cpu_out), .O_CPU_VALID(cpu_valid));

    host_pipe_model i_host_pipe_model (
        .i_clock(clock), .i_busy(busy), .o_op_valid(op_valid), .o_lsw(lsw),
        .o_msw(msw), .o_operand(operand), .o_cpu_data(cpu_in));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            $display("mismatch at %0t: run timed out", $time);
            close_out();
        end
    end

    // MSB-first, no reflection; bits above the width are kept
    function automatic logic [31:0] crc_ref(input int w, input logic [31:0] poly,
                                            input logic [31:0] crc, input logic [7:0] b);
        logic [31:0] c;
        logic [31:0] m;
        c = crc;
        m = (w == 32) ? 32'hFFFF_FFFF : ((32'h1 << w) - 32'h1);
        for (int k = 7; k >= 0; k--) c = (c[w-1] ^ b[k]) ? ((c << 1) ^ poly) : (c << 1);
        return (crc & ~m) | (c & m);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask

    task automatic t_reset();
        chk(crc_res, 32'h0);
        reg_rd(4'h4, 32'h0);
        reg_rd(4'h2, 32'h0);
        reg_wr(4'hC, 32'h1);
        reg_rd(4'hC, 32'h0);
        $display("reset test done");
    endtask

    task automatic t_crc();
        logic [31:0] exp;
        logic [15:0] opnd;
        logic [7:0]  b;
        reg_wr(4'h0, 32'hFFFF_FFFF);
        exp = 32'hFFFF_FFFF;
        for (int f = 0; f < 2; f++) begin
            i_host_pipe_model.issue(f ? 16'hE52C : 16'hE52D, 16'h0, 16'h0, 32'h0);
            chk({31'h0, msg_flip}, {31'h0, f[0]});
            for (int i = 0; i < 10; i++) begin
                opnd = 16'(i * 16'h1B37) ^ 16'h3AC5;
                b = i[0] ? opnd[15:8] : opnd[7:0];
                if (f != 0) b = {<<{b}};
                exp = crc_ref(tab_w[i], tab_poly[i], exp, b);
                i_host_pipe_model.issue(tab_lsw[i], {tab_sub[i], 8'h00}, opnd, 32'h0);
                chk(crc_res, exp);
                chk({31'h0, msg_flip}, {31'h0, f[0]});
            end
        end
        i_host_pipe_model.issue(16'hE527, 16'h0, 16'hFFFF, 32'h0);
        chk(crc_res, exp);
        // Non-zero sub-byte must not pass as the low-byte CRC32
        i_host_pipe_model.issue(16'hE2C1, 16'h0100, 16'hFFFF, 32'h0);
        chk(crc_res, exp);
        // Clear ignores a second word on the port
        i_host_pipe_model.issue(16'hE524, 16'hFFFF, 16'hFFFF, 32'hFFFF_FFFF);
        chk(crc_res, 32'h0);
        chk({31'h0, msg_flip}, 32'h1);
        i_host_pipe_model.issue(16'hE52D, 16'h0, 16'h0, 32'h0);
        chk({31'h0, msg_flip}, 32'h0);
        i_host_pipe_model.idle();
        $display("crc test done");
    endtask

    task automatic t_moves();
        logic [31:0] exp;
        // Let the released lines settle before a new request
        @(posedge clock);
        #1;
        // Byte op is held through the busy cycle and must see the moved value
        i_host_pipe_model.issue(16'hBD00, 16'h0000, 16'h0, 32'hC0DE_1234);
        i_host_pipe_model.issue(16'hE2C1, 16'h0000, 16'h0096, 32'h0);
        exp = crc_ref(32, 32'h04C11DB7, 32'hC0DE_1234, 8'h96);
        chk(crc_res, exp);
        i_host_pipe_model.issue(16'hBF00, 16'h0000, 16'h0, 32'h0);
        i_host_pipe_model.idle();
        chk({31'h0, busy}, 32'h1);
        chk({31'h0, cpu_valid}, 32'h0);
        @(posedge clock);
        #1;
        chk({31'h0, cpu_valid}, 32'h1);
        chk(cpu_out, exp);
        @(posedge clock);
        #1;
        chk({31'h0, cpu_valid}, 32'h0);
        // Other addresses: move in does nothing, move out returns zero
        i_host_pipe_model.issue(16'hBD00, 16'h0010, 16'h0, 32'h1111_2222);
        i_host_pipe_model.issue(16'hBF00, 16'h0010, 16'h0, 32'h0);
        i_host_pipe_model.idle();
        chk(crc_res, exp);
        @(posedge clock);
        #1;
        chk({31'h0, cpu_valid}, 32'h1);
        chk(cpu_out, 32'h0);
        $display("move test done");
    endtask

    task automatic t_regs();
        reg_wr(4'h4, 32'hFFFF_FFFF);
        i_host_pipe_model.issue(16'hE754, 16'h1234, 16'h0, 32'h0);
        i_host_pipe_model.idle();
        reg_rd(4'h4, 32'h0000_1234);
        reg_wr(4'h4, 32'hFFFF_5678);
        i_host_pipe_model.issue(16'hE755, 16'hABCD, 16'h0, 32'h0);
        i_host_pipe_model.idle();
        reg_rd(4'h4, 32'hABCD_5678);
        reg_wr(4'h8, 32'hFFFF_FFFF);
        i_host_pipe_model.issue(16'hE2CB, 16'h0500, 16'h5A5A, 32'h0);
        i_host_pipe_model.idle();
        reg_rd(4'h8, 32'hFFFF_5A5A);
        i_host_pipe_model.issue(16'hE2CB, 16'h0400, 16'h0101, 32'h0);
        i_host_pipe_model.idle();
        reg_rd(4'h8, 32'h0101_5A5A);
        reg_rd(4'hC, 32'h0);
        $display("register test done");
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        addr  = 4'h0;
        wdata = 32'h0;
        wr    = 1'b0;
        rd    = 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1;
        t_reset();
        @(posedge clock);
        t_crc();
        t_moves();
        t_regs();
        close_out();
    end
endmodule // tb_crc_byte_accumulator
